// ---- rtl/rtos_down_timer.sv ----
// Sixteen-bit down-counting timer with APB registers and interrupt.
//
// Added by the designer: the APB register port.
`include "rtos_down_timer_defs.svh"

module rtos_down_timer (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Alternative source enables, one cycle each.
   input  wire logic        undivided_clock_tick,
   input  wire logic        slow_clock_tick,
   // Interrupt and conversion trigger.
   output logic             irq,
   output logic             adc_trigger
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   rtos_down_timer_pkg::timer_state_t st;
   rtos_down_timer_pkg::timer_state_t next_st;
   rtos_down_timer_pkg::ctrl_t        wr_ctrl;
   logic        commit;
   logic        wr_load;
   logic        wr_ctrl_en;
   logic        wr_clear;
   logic        wr_status;
   logic        wr_mask;
   logic        setup;
   logic        tick;
   logic        tc;
   logic        status;
   logic        status_clear;

   // Tells whether an address names a register.
   function automatic logic mapped(input logic [31:0] addr);
      mapped = (addr == `RTOS_LOAD_ADDR) || (addr == `RTOS_COUNT_ADDR) ||
               (addr == `RTOS_CONTROL_ADDR) ||
               (addr == `RTOS_IRQ_CLEAR_ADDR) ||
               (addr == `IRQ_STATUS_ADDR) || (addr == `IRQ_MASK_ADDR);
   endfunction

   // Tells whether a committing write targets one address.
   function automatic logic hit(input logic [31:0] addr,
                                input logic [31:0] want);
      hit = (addr == want);
   endfunction

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------

   // A write commits at the edge where the access phase sees pready.
   assign setup      = psel && !penable &&
                       (st.phase == rtos_down_timer_pkg::ph_idle);
   assign commit     = psel && penable && pwrite &&
                       (st.phase == rtos_down_timer_pkg::ph_answer);
   assign wr_load    = commit && hit(paddr, `RTOS_LOAD_ADDR);
   assign wr_ctrl_en = commit && hit(paddr, `RTOS_CONTROL_ADDR);
   assign wr_clear   = commit && hit(paddr, `RTOS_IRQ_CLEAR_ADDR);
   assign wr_status  = commit && hit(paddr, `IRQ_STATUS_ADDR);
   assign wr_mask    = commit && hit(paddr, `IRQ_MASK_ADDR);

   // Control fields as written; reserved bits are dropped.
   assign wr_ctrl.enable   = pwdata[`CTRL_ENABLE_BIT];
   assign wr_ctrl.periodic = pwdata[`CTRL_PERIODIC_BIT];
   assign wr_ctrl.src      = rtos_down_timer_pkg::clk_src_t'(
                                pwdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB]);
   assign wr_ctrl.div      = rtos_down_timer_pkg::prescale_t'(
                                pwdata[`CTRL_DIV_MSB:`CTRL_DIV_LSB]);

   // Any data written to the clear register drops the request.
   assign status_clear = wr_clear ||
                         (wr_status && pwdata[`STATUS_TC_BIT]);

   // Reaching zero is a tick taking the count from one to zero.
   assign tc = st.ctrl.enable && tick && !wr_ctrl_en &&
               (st.count == 16'h0001);

   // -------------------------------------------------------------------------
   // Submodules
   // -------------------------------------------------------------------------

   // Prescaler restarts on each control write.
   rtos_prescaler u_prescaler (
      .pclk           (pclk),
      .presetn        (presetn),
      .src            (st.ctrl.src),
      .div            (st.ctrl.div),
      .run            (st.ctrl.enable),
      .restart        (wr_ctrl_en),
      .undivided_tick (undivided_clock_tick),
      .slow_tick      (slow_clock_tick),
      .tick           (tick)
   );

   // Pending terminal-count flag.
   rtos_sticky_flags #(
      .WIDTH (1)
   ) u_flags (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (tc),
      .clear   (status_clear),
      .flags   (status)
   );

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------

   // Bus answer, register writes, counting and event outputs.
   always_comb begin
      next_st      = st;
      next_st.trig = tc;
      next_st.irq  = status && st.mask;
      unique case (st.phase)
         rtos_down_timer_pkg::ph_idle: begin
            if (setup) begin
               next_st.phase  = rtos_down_timer_pkg::ph_answer;
               next_st.slverr = !mapped(paddr);
               next_st.rdata  = 32'h0000_0000;
               if (!pwrite) begin
                  if (paddr == `RTOS_LOAD_ADDR) begin
                     next_st.rdata = {16'h0000, st.load};
                  end else if (paddr == `RTOS_COUNT_ADDR) begin
                     next_st.rdata = {16'h0000, st.count};
                  end else if (paddr == `RTOS_CONTROL_ADDR) begin
                     next_st.rdata = {24'h00_0000, st.ctrl, 2'h0};
                  end else if (paddr == `IRQ_STATUS_ADDR) begin
                     next_st.rdata = {31'h0000_0000, status};
                  end else if (paddr == `IRQ_MASK_ADDR) begin
                     next_st.rdata = {31'h0000_0000, st.mask};
                  end
               end
            end
         end
         rtos_down_timer_pkg::ph_answer: begin
            next_st.phase = rtos_down_timer_pkg::ph_idle;
         end
      endcase
      if (wr_load) begin
         next_st.load = pwdata[15:0];
      end
      if (wr_mask) begin
         next_st.mask = pwdata[`STATUS_TC_BIT];
      end
      if (wr_ctrl_en) begin
         // A control write starts the count afresh.
         next_st.ctrl  = wr_ctrl;
         next_st.count = wr_ctrl.periodic ? st.load : `COUNT_RESET;
      end else if (st.ctrl.enable && tick) begin
         if (st.count == 16'h0000) begin
            if (st.ctrl.periodic) begin
               next_st.count = st.load;
            end else begin
               next_st.count = `COUNT_RESET;
            end
         end else begin
            next_st.count = st.count - 16'h0001;
         end
      end
   end

   // -------------------------------------------------------------------------
   // State register and outputs
   // -------------------------------------------------------------------------

   // All state in one register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st       <= '0;
         st.load  <= `LOAD_RESET;
         st.count <= `COUNT_RESET;
         st.mask  <= `MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state register.
   assign prdata      = st.rdata;
   assign pready      = (st.phase == rtos_down_timer_pkg::ph_answer);
   assign pslverr     = st.slverr;
   assign irq         = st.irq;
   assign adc_trigger = st.trig;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------

   // Enabled ticks at a nonzero count step it down by one.
   property p_count_down;
      @(posedge pclk) disable iff (!presetn)
      (st.ctrl.enable && tick && !wr_ctrl_en && st.count != 16'h0000)
      |=> (st.count == $past(st.count) - 16'h0001);
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("count did not step down by one");

   // Free-running mode wraps from zero to full scale.
   property p_free_wrap;
      @(posedge pclk) disable iff (!presetn)
      (st.ctrl.enable && !st.ctrl.periodic && tick && !wr_ctrl_en &&
       st.count == 16'h0000) |=> (st.count == 16'hffff);
   endproperty
   a_free_wrap: assert property (p_free_wrap)
      else $error("free-running count did not wrap to full scale");

   // Periodic mode reloads from the load register at zero.
   property p_periodic_reload;
      @(posedge pclk) disable iff (!presetn)
      (st.ctrl.enable && st.ctrl.periodic && tick && !wr_ctrl_en &&
       st.count == 16'h0000) |=> (st.count == $past(st.load));
   endproperty
   a_periodic_reload: assert property (p_periodic_reload)
      else $error("periodic count did not reload");

   // A disabled timer holds its count.
   property p_disabled_hold;
      @(posedge pclk) disable iff (!presetn)
      (!st.ctrl.enable && !wr_ctrl_en) |=> $stable(st.count);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("disabled timer changed its count");

   // Reaching zero sets the request and, if unmasked, the interrupt.
   property p_tc_irq;
      @(posedge pclk) disable iff (!presetn)
      (tc && st.mask && !wr_mask) |=> status ##1 irq;
   endproperty
   a_tc_irq: assert property (p_tc_irq)
      else $error("terminal count did not raise the interrupt");

   // A clear write without a new event drops the request.
   property p_clear_drops;
      @(posedge pclk) disable iff (!presetn)
      (wr_clear && !tc) |=> !status;
   endproperty
   a_clear_drops: assert property (p_clear_drops)
      else $error("clear write left the request pending");

   // A new event wins over a coinciding clear.
   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      (status_clear && tc) |=> status;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a coinciding terminal count");

   // The trigger is a single pulse after each terminal count.
   property p_trigger;
      @(posedge pclk) disable iff (!presetn)
      tc |=> adc_trigger ##1 (adc_trigger == $past(tc));
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("conversion trigger did not follow terminal count");

   // A read of the value register returns the count of the setup cycle.
   property p_read_count;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `RTOS_COUNT_ADDR)
      |=> (pready && prdata == {16'h0000, $past(st.count)});
   endproperty
   a_read_count: assert property (p_read_count)
      else $error("value read did not return the current count");

   // A control write loads the start value for the chosen mode.
   property p_start;
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl_en |=> (st.count == ($past(pwdata[`CTRL_PERIODIC_BIT]) ?
                                   $past(st.load) : 16'hffff));
   endproperty
   a_start: assert property (p_start)
      else $error("control write did not restart the count");

   // A pending request stays set until a clear strobe.
   property p_irq_holds;
      @(posedge pclk) disable iff (!presetn)
      (status && !status_clear) |=> status;
   endproperty
   a_irq_holds: assert property (p_irq_holds)
      else $error("pending request dropped without a clear");

   // An unmasked pending request drives the interrupt line.
   property p_irq_follows;
      @(posedge pclk) disable iff (!presetn)
      (status && st.mask) |=> irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("unmasked request did not raise the interrupt");

   // With no request pending the interrupt line falls.
   property p_irq_drops;
      @(posedge pclk) disable iff (!presetn)
      !status |=> !irq;
   endproperty
   a_irq_drops: assert property (p_irq_drops)
      else $error("interrupt stayed high with no request pending");

   // A load write stores the low half of the bus data.
   property p_load_write;
      @(posedge pclk) disable iff (!presetn)
      wr_load |=> (st.load == $past(pwdata[15:0]));
   endproperty
   a_load_write: assert property (p_load_write)
      else $error("load write did not store the data");

   // A disabled timer gets no prescaler ticks.
   property p_disabled_tick;
      @(posedge pclk) disable iff (!presetn)
      !st.ctrl.enable |-> !tick;
   endproperty
   a_disabled_tick: assert property (p_disabled_tick)
      else $error("disabled timer received a tick");

   // The reserved source code gives no ticks at all.
   property p_reserved_src;
      @(posedge pclk) disable iff (!presetn)
      (st.ctrl.src == rtos_down_timer_pkg::src_reserved) |-> !tick;
   endproperty
   a_reserved_src: assert property (p_reserved_src)
      else $error("reserved source produced a tick");

   // Prescale code 11 ticks on every core cycle, like divide by one.
   property p_div_alt;
      @(posedge pclk) disable iff (!presetn)
      (st.ctrl.enable && !wr_ctrl_en &&
       st.ctrl.src == rtos_down_timer_pkg::src_core &&
       st.ctrl.div == rtos_down_timer_pkg::div_1_alt) |-> tick;
   endproperty
   a_div_alt: assert property (p_div_alt)
      else $error("prescale code 11 did not divide by one");

   // Main scenarios.
   c_periodic_tc: cover property (@(posedge pclk) disable iff (!presetn)
      tc && st.ctrl.periodic);
   c_free_wrap: cover property (@(posedge pclk) disable iff (!presetn)
      st.ctrl.enable && !st.ctrl.periodic && tick && st.count == 16'h0000);
   c_set_wins: cover property (@(posedge pclk) disable iff (!presetn)
      tc && wr_clear);
   c_count_read: cover property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == `RTOS_COUNT_ADDR);
   c_irq_clear: cover property (@(posedge pclk) disable iff (!presetn)
      wr_clear && status);

endmodule // rtos_down_timer

// ---- rtl/rtos_down_timer_defs.svh ----
// Register map, field positions, reset values and counts of the timer.
`ifndef RTOS_DOWN_TIMER_DEFS_SVH
`define RTOS_DOWN_TIMER_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define RTOS_LOAD_ADDR        32'hffff_0300
`define RTOS_COUNT_ADDR       32'hffff_0304
`define RTOS_CONTROL_ADDR     32'hffff_0308
`define RTOS_IRQ_CLEAR_ADDR   32'hffff_030c
`define IRQ_STATUS_ADDR       32'hffff_0310
`define IRQ_MASK_ADDR         32'hffff_0314

// ----------------------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------------------
`define CTRL_ENABLE_BIT       7
`define CTRL_PERIODIC_BIT     6
`define CTRL_SRC_MSB          5
`define CTRL_SRC_LSB          4
`define CTRL_DIV_MSB          3
`define CTRL_DIV_LSB          2
`define STATUS_TC_BIT         0

// ----------------------------------------------------------------------------
// Reset values and prescaler counts
// ----------------------------------------------------------------------------
`define LOAD_RESET            16'h0000
`define COUNT_RESET           16'hffff
`define MASK_RESET            1'h1
`define DIV16_LAST            8'h0f
`define DIV256_LAST           8'hff
`define DIV1_LAST             8'h00

`endif

// ---- rtl/rtos_down_timer_pkg.sv ----
// Types shared by the timer and its prescaler.
package rtos_down_timer_pkg;

   // Prescaler source select.
   typedef enum logic [1:0] {
      src_core      = 2'h0,
      src_undivided = 2'h1,
      src_slow      = 2'h2,
      src_reserved  = 2'h3
   } clk_src_t;

   // Prescale division select.
   typedef enum logic [1:0] {
      div_1     = 2'h0,
      div_16    = 2'h1,
      div_256   = 2'h2,
      div_1_alt = 2'h3
   } prescale_t;

   // Bus answer phase.
   typedef enum logic {
      ph_idle   = 1'h0,
      ph_answer = 1'h1
   } apb_phase_t;

   // Control register fields, bits 7:2.
   typedef struct packed {
      logic      enable;
      logic      periodic;
      clk_src_t  src;
      prescale_t div;
   } ctrl_t;

   // Whole state of the timer top.
   typedef struct packed {
      apb_phase_t  phase;
      logic [31:0] rdata;
      logic        slverr;
      ctrl_t       ctrl;
      logic [15:0] load;
      logic [15:0] count;
      logic        mask;
      logic        irq;
      logic        trig;
   } timer_state_t;

   // Whole state of the prescaler.
   typedef struct packed {
      logic [7:0] cnt;
   } prescaler_state_t;

endpackage

// ---- rtl/rtos_prescaler.sv ----
// Source select and divider producing the counter's tick enable.
`include "rtos_down_timer_defs.svh"

module rtos_prescaler (
   // Clock and reset.
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // Selection and run control.
   input  wire rtos_down_timer_pkg::clk_src_t  src,
   input  wire rtos_down_timer_pkg::prescale_t div,
   input  wire logic                       run,
   input  wire logic                       restart,
   // Source enables.
   input  wire logic                       undivided_tick,
   input  wire logic                       slow_tick,
   // Counter tick.
   output logic                            tick
);

   rtos_down_timer_pkg::prescaler_state_t st;
   rtos_down_timer_pkg::prescaler_state_t next_st;
   logic       src_tick;
   logic [7:0] last;

   // Pick the source enable; the reserved code gives no ticks.
   always_comb begin
      unique case (src)
         rtos_down_timer_pkg::src_core:      src_tick = 1'b1;
         rtos_down_timer_pkg::src_undivided: src_tick = undivided_tick;
         rtos_down_timer_pkg::src_slow:      src_tick = slow_tick;
         rtos_down_timer_pkg::src_reserved:  src_tick = 1'b0;
      endcase
      unique case (div)
         rtos_down_timer_pkg::div_16:    last = `DIV16_LAST;
         rtos_down_timer_pkg::div_256:   last = `DIV256_LAST;
         rtos_down_timer_pkg::div_1,
         rtos_down_timer_pkg::div_1_alt: last = `DIV1_LAST;
      endcase
   end

   // One tick per prescale count of source enables.
   assign tick = run && !restart && src_tick && (st.cnt == last);

   // Divider count, cleared on restart and while stopped.
   always_comb begin
      next_st = st;
      if (restart || !run) begin
         next_st.cnt = 8'h00;
      end else if (src_tick) begin
         next_st.cnt = (st.cnt == last) ? 8'h00 : st.cnt + 8'h01;
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // rtos_prescaler

// ---- rtl/rtos_sticky_flags.sv ----
// Sticky status flags, set by events, cleared by software.
module rtos_sticky_flags #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Event and clear strobes.
   input  wire logic [WIDTH-1:0] set,
   input  wire logic [WIDTH-1:0] clear,
   // Flag levels.
   output logic      [WIDTH-1:0] flags
);

   logic [WIDTH-1:0] next_flags;

   // A set in the same cycle as a clear keeps the flag high.
   always_comb begin
      next_flags = (flags & ~clear) | set;
   end

   // Flag register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

endmodule // rtos_sticky_flags

// ---- testbench/rtos_down_timer_tb_top.sv ----
// Self-checking testbench of the sixteen-bit down-counting timer.
`include "rtos_down_timer_defs.svh"

module rtos_down_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------------
   // Signals, counters and clock
   // ------------------------------------------------------------------------
   localparam int LIMIT = 80000;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        undivided_clock_tick;
   logic        slow_clock_tick;
   logic        irq;
   logic        adc_trigger;
   logic [31:0] v;
   logic [31:0] w;
   logic        e;
   int          bad_count;
   int          checks_done;
   int          cycles;
   int          ucnt;
   int          scnt;
   int          n;

   // Free-running clock of 25 ns.
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   rtos_down_timer rtos_down_timer_i (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .undivided_clock_tick (undivided_clock_tick),
      .slow_clock_tick      (slow_clock_tick),
      .irq                  (irq),
      .adc_trigger          (adc_trigger)
   );

   // Source enables: undivided every 3 cycles, slow every 5; hang guard.
   always @(posedge pclk) begin
      ucnt <= (ucnt == 2) ? 0 : ucnt + 1;
      scnt <= (scnt == 4) ? 0 : scnt + 1;
      undivided_clock_tick <= (ucnt == 0);
      slow_clock_tick <= (scnt == 0);
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         complete_run();
      end
   end

   // ------------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------------
   // Compares a seen value with the expected one and counts both outcomes.
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  want);
      end
   endtask

   // One APB transfer; waits for pready, then releases the request.
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      v = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Measures cycles between two conversion trigger pulses.
   task automatic period(output int p);
      int k;
      k = 0;
      @(negedge pclk);
      while (adc_trigger !== 1'b1 && k < 70000) begin
         @(negedge pclk);
         k++;
      end
      p = 1;
      @(negedge pclk);
      while (adc_trigger !== 1'b1 && p < 70000) begin
         @(negedge pclk);
         p++;
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------------
   // Reset values, read-only value, unmapped place and reserved bits.
   task automatic t_regs();
      apb(0, `RTOS_COUNT_ADDR, 0);   check(v, 32'h0000_ffff);
      apb(0, `RTOS_CONTROL_ADDR, 0); check(v, 32'h0000_0000);
      apb(0, `IRQ_MASK_ADDR, 0);     check(v, 32'h0000_0001);
      apb(0, `RTOS_LOAD_ADDR, 0);    check(v, 32'h0000_0000);
      apb(1, `RTOS_LOAD_ADDR, 32'h1234_abcd);
      apb(0, `RTOS_LOAD_ADDR, 0);    check(v, 32'h0000_abcd);
      apb(1, `RTOS_COUNT_ADDR, 32'h0000_0007);
      apb(0, `RTOS_COUNT_ADDR, 0);   check(v, 32'h0000_ffff);
      apb(0, 32'hffff_0318, 0);      check({v[30:0], e}, 32'h0000_0001);
      apb(0, `RTOS_IRQ_CLEAR_ADDR, 0); check(v, 32'h0000_0000);
      apb(1, `RTOS_CONTROL_ADDR, 32'hffff_ff3f);
      apb(0, `RTOS_CONTROL_ADDR, 0); check(v, 32'h0000_003c);
   endtask

   // A control write loads the start value; disabled, the count stays.
   task automatic t_reload();
      apb(1, `RTOS_LOAD_ADDR, 32'h0000_0005);
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_0040);
      repeat (10) @(posedge pclk);
      apb(0, `RTOS_COUNT_ADDR, 0);   check(v, 32'h0000_0005);
      // Undivided source: read twice, and a third time if they differ.
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_0090);
      apb(0, `RTOS_COUNT_ADDR, 0);
      w = v;
      apb(0, `RTOS_COUNT_ADDR, 0);
      if (w != v) begin
         w = v;
         apb(0, `RTOS_COUNT_ADDR, 0);
      end
      check(w - v, 32'h0000_0001);
   endtask

   // Terminal count spacing for each prescale and source code.
   task automatic t_periods();
      logic [31:0] ctl[6] = '{32'h0000_00c0, 32'h0000_00c4, 32'h0000_00c8,
                              32'h0000_00cc, 32'h0000_00d0, 32'h0000_00e0};
      int          exp[6] = '{2, 32, 512, 2, 6, 10};
      apb(1, `RTOS_LOAD_ADDR, 32'h0000_0001);
      for (int i = 0; i < 6; i++) begin
         apb(1, `RTOS_CONTROL_ADDR, ctl[i]);
         period(n);
         check(n, exp[i]);
      end
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_00f0);
      n = 0;
      repeat (100) @(negedge pclk) n += adc_trigger;
      check(n, 0);
   endtask

   // Free-running count goes down each cycle and wraps at full scale.
   task automatic t_free();
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_0080);
      apb(0, `RTOS_COUNT_ADDR, 0);
      w = v;
      apb(0, `RTOS_COUNT_ADDR, 0);   check(w - v, 32'h0000_0003);
      n = 0;
      while (adc_trigger !== 1'b1 && n < 70000) begin
         @(negedge pclk);
         n++;
      end
      check(n, 65530);
      apb(0, `RTOS_COUNT_ADDR, 0);   check(v, 32'h0000_ffff);
   endtask

   // Interrupt holds, clears on any write, masks and clears by status.
   task automatic t_irq();
      apb(1, `RTOS_IRQ_CLEAR_ADDR, 32'h0000_0000);
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_00c0);
      period(n);
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_0000);
      repeat (20) @(posedge pclk);
      check(irq, 1'b1);
      apb(1, `RTOS_IRQ_CLEAR_ADDR, 32'h0000_0000);
      apb(0, `IRQ_STATUS_ADDR, 0);   check(v, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
      apb(1, `IRQ_MASK_ADDR, 32'h0000_0000);
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_00c0);
      period(n);
      apb(1, `RTOS_CONTROL_ADDR, 32'h0000_0000);
      apb(0, `IRQ_STATUS_ADDR, 0);   check({v[30:0], irq}, 32'h0000_0002);
      apb(1, `IRQ_STATUS_ADDR, 32'h0000_0001);
      apb(0, `IRQ_STATUS_ADDR, 0);   check(v, 32'h0000_0000);
   endtask

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   // Drives idle inputs, resets for 3 cycles, then runs every scenario.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      undivided_clock_tick = 1'b0;
      slow_clock_tick = 1'b0;
      bad_count = 0;
      checks_done = 0;
      cycles = 0;
      ucnt = 0;
      scnt = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_reload();
      t_periods();
      t_irq();
      t_free();
      complete_run();
   end
endmodule // rtos_down_timer_tb_top
